// ---- rtl/slcd_map.svh ----
// Register indices, field positions, reset values and timing figures of the segment display timer.
`ifndef SLCD_MAP_SVH
`define SLCD_MAP_SVH

`define SLCD_IDX_FLAG        9'h00C
`define SLCD_IDX_PRESCALE    9'h10E
`define SLCD_IDX_CONTROL     9'h10F
`define SLCD_IDX_PIX_BASE    9'h110
`define SLCD_IDX_PIX_LAST    9'h11F
`define SLCD_PIX_REGS        16

`define SLCD_FLAG_BIT        7
`define SLCD_CTL_DRIVE_BIT   7
`define SLCD_CTL_SLEEP_BIT   6
`define SLCD_CTL_INTERNAL_VOLTAGE_GEN_ON_BIT    4

`define SLCD_CTL_RESET       8'h00
`define SLCD_PS_RESET        8'h00
`define SLCD_CTL_WMASK       8'hDF
`define SLCD_PS_WMASK        8'h0F

`define SLCD_FOSC_DIV        256
`define SLCD_FRAME_TICKS_STD 128
`define SLCD_FRAME_TICKS_3C  96
`define SLCD_PCLK_HZ         250000000
`define SLCD_RC_HZ           14000

`endif

// ---- rtl/slcd_pkg.sv ----
// Types shared by the segment display timer modules.
package slcd_pkg;

	typedef struct packed {
		logic       drive_enable;
		logic       stop_in_sleep;
		logic       unused;
		logic       internal_voltage_gen_on;
		logic [1:0] timing_clock_select;
		logic [1:0] common_count_select;
	} slcd_ctl_t;

	typedef enum logic [1:0] {
		SRC_FOSC,
		SRC_TIMER1,
		SRC_RC
	} slcd_src_t;

	typedef struct packed {
		logic [3:0]  commons;
		logic [31:0] segments;
	} slcd_drive_t;

endpackage

// ---- rtl/slcd_frame_gen.sv ----
// Common slot and frame divider of the segment display timer.
`include "slcd_map.svh"

module slcd_frame_gen #(
	parameter int PW = 4
) (
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// Control
	input  wire logic          run,
	input  wire logic          src_tick,
	input  wire logic [1:0]    mux,
	input  wire logic [PW-1:0] prescale,
	// Timing
	output logic [1:0]         com_idx,
	output logic               slot_start
);

	logic [11:0] count_ff;
	logic [1:0]  idx_ff;
	logic [11:0] slot_len;

	// Each frame is split evenly among the commons, so one slot is frame ticks over commons.
	function automatic logic [11:0] slot_len_f(input logic [1:0] m, input logic [PW-1:0] p);
		logic [11:0] base;
		base = 12'(`SLCD_FRAME_TICKS_STD / 4);
		case (m)
			2'b00: base = 12'(`SLCD_FRAME_TICKS_STD);
			2'b01: base = 12'(`SLCD_FRAME_TICKS_STD / 2);
			2'b10: base = 12'(`SLCD_FRAME_TICKS_3C / 3);
			default: base = 12'(`SLCD_FRAME_TICKS_STD / 4);
		endcase
		return 12'(base * (12'(p) + 12'h001));
	endfunction

	assign slot_len   = slot_len_f(mux, prescale);
	assign slot_start = run && src_tick && (count_ff == 12'h000);
	// A smaller mode written mid-slot must not leave a common above the new range.
	assign com_idx    = (idx_ff > mux) ? 2'h0 : idx_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff <= 12'h000;
		end else if (!run) begin
			count_ff <= 12'h000;
		end else if (src_tick) begin
			// A shortened prescale must not strand the count above the new length.
			if (count_ff >= slot_len - 12'h001) begin
				count_ff <= 12'h000;
			end else begin
				count_ff <= count_ff + 12'h001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_ff <= 2'h0;
		end else if (!run) begin
			idx_ff <= 2'h0;
		end else if (src_tick && count_ff >= slot_len - 12'h001) begin
			idx_ff <= (idx_ff >= mux) ? 2'h0 : idx_ff + 2'h1;
		end
	end

endmodule // slcd_frame_gen

// ---- rtl/slcd_timing.sv ----
// Segment display timing controller with its APB register file and pixel store.
// Operation
// - Control bit 7 enables panel drive; clear disables it.
// - Control bit 6 set halts the block while the processor sleeps.
// - Control bit 5 is unimplemented and reads zero.
// - Control bit 4 powers the internal voltage generator; clear expects external voltages.
// - Control bits 3:2 pick system clock/256, timer1 input, or internal RC.
// - Control bits 1:0 pick static, two, three or four commons.
// - Prescale bits 7:4 read zero; bits 3:0 hold the frame prescale.
// - Static, two and four common frames last 128 times prescale plus one ticks.
// - Three common frames last 96 times prescale plus one ticks.
// - Internal RC source runs at a nominal 14 kHz.
// - RC source is off unless selected and the block is enabled.
// - System clock passes a fixed divide by 256 stage.
// - One to four commons are driven, following the multiplex mode.
// - Leading edge of the first common starts each frame.
// - Frame flag rises once all pixel bits of the frame are fetched.
// - Fetching for the next frame starts within the frame write window.
// - Each pixel bit controls one pixel at one segment and common.
// - Unused pixel bits act as ordinary read-write storage.
// - Pixel bit one drives the pixel dark, zero leaves it clear.
// - Sleep with stop set halts at once with minimum voltage on all lines.
// - Only RC or timer1 sources keep the display running in sleep.
// - Frame flag is bit 7 of the flag register; software clears it first.
//
// Register access over APB is this design's own decision.
`include "slcd_map.svh"

module slcd_timing #(
	parameter int          PW     = 4,
	parameter int unsigned RC_DIV = `SLCD_PCLK_HZ / `SLCD_RC_HZ
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Processor and oscillator status
	input  wire logic              cpu_sleep,
	input  wire logic              timer1_clock_input,
	// Panel drive
	output slcd_pkg::slcd_drive_t  panel,
	output logic                   min_voltage,
	output logic                   internal_voltage_gen_on,
	output logic                   rc_osc_on,
	output logic                   frame_start,
	output logic                   frame_interrupt_flag
);

	slcd_pkg::slcd_ctl_t ctl_ff;
	logic [PW-1:0]       frame_prescale_value_ff;
	logic [7:0]          pix_mem [`SLCD_PIX_REGS];
	logic                flag_ff;
	logic [31:0]         prdata_ff;
	logic                pready_ff;
	logic                pslverr_ff;
	slcd_pkg::slcd_drive_t drive_ff;
	logic                min_v_ff;
	logic                internal_voltage_gen_on_ff;
	logic                rc_on_ff;
	logic                frame_start_ff;
	logic [7:0]          fosc_cnt_ff;
	logic [31:0]         rc_cnt_ff;
	logic                t1_prev_ff;
	logic                src_tick;
	logic                halted;
	logic                run;
	logic [1:0]          com_idx;
	logic                slot_start;
	logic                apb_done;
	logic                apb_wr;
	logic [8:0]          idx;
	logic                flag_set;
	slcd_pkg::slcd_src_t src;

	function automatic slcd_pkg::slcd_src_t src_f(input logic [1:0] cs);
		case (cs)
			2'b00: return slcd_pkg::SRC_FOSC;
			2'b01: return slcd_pkg::SRC_TIMER1;
			default: return slcd_pkg::SRC_RC;
		endcase
	endfunction

	function automatic logic is_pix(input logic [8:0] i);
		return (i >= `SLCD_IDX_PIX_BASE) && (i <= `SLCD_IDX_PIX_LAST);
	endfunction

	function automatic logic [3:0] pix_sel(input logic [8:0] i);
		return 4'(i - `SLCD_IDX_PIX_BASE);
	endfunction

	assign idx      = paddr[10:2];
	assign apb_done = psel && penable && pready_ff;
	assign apb_wr   = apb_done && pwrite;
	assign src      = src_f(ctl_ff.timing_clock_select);

	// The system clock stops in sleep, so that source cannot carry the display through it.
	assign halted = cpu_sleep && (ctl_ff.stop_in_sleep || src == slcd_pkg::SRC_FOSC);
	assign run    = ctl_ff.drive_enable && !halted;

	// Register writes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_ff                  <= slcd_pkg::slcd_ctl_t'(`SLCD_CTL_RESET);
			frame_prescale_value_ff <= PW'(`SLCD_PS_RESET);
		end else if (apb_wr && idx == `SLCD_IDX_CONTROL) begin
			ctl_ff <= slcd_pkg::slcd_ctl_t'(pwdata[7:0] & `SLCD_CTL_WMASK);
		end else if (apb_wr && idx == `SLCD_IDX_PRESCALE) begin
			frame_prescale_value_ff <= PW'(pwdata[7:0] & `SLCD_PS_WMASK);
		end
	end

	// Pixel store has no reset, like ordinary RAM; every bit is writable.
	always_ff @(posedge pclk) begin
		if (apb_wr && is_pix(idx)) begin
			pix_mem[pix_sel(idx)] <= pwdata[7:0];
		end
	end

	// One wait state lets read data leave a flip-flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end else if (psel && penable && !pready_ff) begin
			pready_ff  <= 1'b1;
			pslverr_ff <= !(is_pix(idx) || idx == `SLCD_IDX_CONTROL ||
				idx == `SLCD_IDX_PRESCALE || idx == `SLCD_IDX_FLAG);
			prdata_ff  <= 32'h00000000;
			if (!pwrite) begin
				if (is_pix(idx)) begin
					prdata_ff <= {24'h000000, pix_mem[pix_sel(idx)]};
				end else if (idx == `SLCD_IDX_CONTROL) begin
					prdata_ff <= {24'h000000, ctl_ff & `SLCD_CTL_WMASK};
				end else if (idx == `SLCD_IDX_PRESCALE) begin
					prdata_ff <= {24'h000000, 8'(frame_prescale_value_ff)};
				end else if (idx == `SLCD_IDX_FLAG) begin
					prdata_ff <= {24'h000000, flag_ff, 7'h00};
				end
			end
		end else begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

	// Fixed divide by 256 of the bus clock; no ratio is programmable here.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fosc_cnt_ff <= 8'h00;
		end else begin
			fosc_cnt_ff <= fosc_cnt_ff + 8'h01;
		end
	end

	// Internal RC source, modelled as a divider that only runs while it is powered.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_cnt_ff <= 32'h00000000;
		end else if (!rc_on_ff || rc_cnt_ff >= 32'(RC_DIV - 1)) begin
			rc_cnt_ff <= 32'h00000000;
		end else begin
			rc_cnt_ff <= rc_cnt_ff + 32'h00000001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_on_ff <= 1'b0;
		end else begin
			rc_on_ff <= ctl_ff.drive_enable && src == slcd_pkg::SRC_RC;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t1_prev_ff <= 1'b0;
		end else begin
			t1_prev_ff <= timer1_clock_input;
		end
	end

	// Timer1 input is synchronous already; its oscillator is enabled elsewhere.
	always_comb begin
		case (src)
			slcd_pkg::SRC_FOSC: src_tick = (fosc_cnt_ff == 8'hFF);
			slcd_pkg::SRC_TIMER1: src_tick = timer1_clock_input && !t1_prev_ff;
			default: src_tick = rc_on_ff && (rc_cnt_ff == 32'(RC_DIV - 1));
		endcase
	end

	slcd_frame_gen #(
		.PW (PW)
	) u_frame (
		.pclk       (pclk),
		.presetn    (presetn),
		.run        (run),
		.src_tick   (src_tick),
		.mux        (ctl_ff.common_count_select),
		.prescale   (frame_prescale_value_ff),
		.com_idx    (com_idx),
		.slot_start (slot_start)
	);

	// Each common slot fetches its 32 pixel bits; bit s of word c is segment s on common c.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_ff <= '0;
			min_v_ff <= 1'b1;
		end else if (!run) begin
			drive_ff <= '0;
			min_v_ff <= 1'b1;
		end else if (slot_start) begin
			drive_ff.commons  <= 4'h1 << com_idx;
			drive_ff.segments <= {pix_mem[{com_idx, 2'h3}], pix_mem[{com_idx, 2'h2}],
				pix_mem[{com_idx, 2'h1}], pix_mem[{com_idx, 2'h0}]};
			min_v_ff          <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_start_ff <= 1'b0;
		end else begin
			frame_start_ff <= slot_start && com_idx == 2'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			internal_voltage_gen_on_ff <= 1'b0;
		end else begin
			internal_voltage_gen_on_ff <= ctl_ff.internal_voltage_gen_on && !halted;
		end
	end

	// Fetch of the last common ends the frame's data access, one slot before the boundary.
	assign flag_set = run && slot_start && com_idx == ctl_ff.common_count_select;

	// A set in the same cycle as a software clear wins, so no frame is lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_ff <= 1'b0;
		end else if (flag_set) begin
			flag_ff <= 1'b1;
		end else if (apb_wr && idx == `SLCD_IDX_FLAG) begin
			flag_ff <= pwdata[`SLCD_FLAG_BIT];
		end
	end

	assign prdata               = prdata_ff;
	assign pready               = pready_ff;
	assign pslverr              = pslverr_ff;
	assign panel                = drive_ff;
	assign min_voltage          = min_v_ff;
	assign internal_voltage_gen_on = internal_voltage_gen_on_ff;
	assign rc_osc_on            = rc_on_ff;
	assign frame_start          = frame_start_ff;
	assign frame_interrupt_flag = flag_ff;

	disabled_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ctl_ff.drive_enable |=> (panel.commons == 4'h0 && min_voltage))
		else $error("panel driven while drive is disabled");

	sleep_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_sleep && ctl_ff.stop_in_sleep) |=> (panel == '0 && min_voltage))
		else $error("panel not at minimum voltage in stopped sleep");

	ctl_bit5_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && paddr[10:2] == `SLCD_IDX_CONTROL) |-> prdata[5] == 1'b0)
		else $error("control bit 5 read as one");

	ps_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && paddr[10:2] == `SLCD_IDX_PRESCALE) |-> prdata[7:4] == 4'h0)
		else $error("prescale upper bits read as nonzero");

	rc_power_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!ctl_ff.drive_enable || !ctl_ff.timing_clock_select[1]) |=> !rc_osc_on)
		else $error("RC source powered while unused");

	fosc_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_sleep && src == slcd_pkg::SRC_FOSC) |=> !frame_start)
		else $error("frame started from system clock during sleep");

	one_common_a: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot0(panel.commons) && (!$past(slot_start && run) ||
			panel.commons <= (4'h1 << $past(ctl_ff.common_count_select))))
		else $error("common outside the selected multiplex range");

	flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(frame_interrupt_flag && !(apb_wr && idx == `SLCD_IDX_FLAG)) |=> frame_interrupt_flag)
		else $error("frame flag dropped without a clear");

	flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(frame_interrupt_flag) |-> $past(slot_start && run))
		else $error("frame flag rose without a final fetch");

	apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready) |=> pready)
		else $error("APB access not answered after one wait state");

	fetch_data_a: assert property (@(posedge pclk) disable iff (!presetn)
		(slot_start && run && com_idx == 2'h0) |=> panel.segments[7:0] == $past(pix_mem[0]))
		else $error("segment data does not follow pixel bits");

endmodule // slcd_timing

// ---- test/slcd_panel_model.sv ----
// Panel model that records which commons were driven and the segments seen on each.
module slcd_panel_model (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// Drive from the timer
	input  wire slcd_pkg::slcd_drive_t panel,
	input  wire logic                  min_voltage,
	// Observation control and results
	input  wire logic                  clr,
	output logic [3:0]                 seen_ff,
	output logic [31:0]                seg_ff [4],
	output logic                       bad_ff
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_ff <= 4'h0;
			bad_ff  <= 1'h0;
		end else begin
			if (clr) begin
				seen_ff <= 4'h0;
			end else begin
				seen_ff <= seen_ff | panel.commons;
			end
			// A real panel would be damaged by two commons at once or drive while parked.
			if (!$onehot0(panel.commons) || (min_voltage && panel.commons != 4'h0)) begin
				bad_ff <= 1'h1;
			end
			for (int c = 0; c < 4; c++) begin
				if (panel.commons[c]) begin
					seg_ff[c] <= panel.segments;
				end
			end
		end
	end
endmodule // slcd_panel_model

// ---- test/testbench.sv ----
// Self-checking bench for the segment display timer.
`include "slcd_map.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int RCD = 4;

	logic                  pclk        = 1'h0;
	logic                  presetn     = 1'h0;
	logic                  psel        = 1'h0;
	logic                  penable     = 1'h0;
	logic                  pwrite      = 1'h0;
	logic [11:0]           paddr       = 12'h000;
	logic [31:0]           pwdata      = 32'h0;
	logic                  cpu_sleep   = 1'h0;
	logic                  t1_in       = 1'h0;
	logic                  t1_run      = 1'h0;
	logic                  clr         = 1'h0;
	int                    n_mismatch  = 0;
	int                    check_count = 0;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	slcd_pkg::slcd_drive_t panel;
	logic                  min_v;
	logic                  internal_voltage_gen_on_on;
	logic                  rc_on;
	logic                  frame_start;
	logic                  flag;
	logic [3:0]            seen;
	logic [31:0]           seg [4];
	logic                  bad;
	logic [31:0]           rd;
	logic                  er;
	int                    cyc;
	int                    n;

	always #2 pclk = ~pclk;
	always @(posedge pclk) if (t1_run) t1_in <= ~t1_in;

	slcd_timing #(.PW(4), .RC_DIV(RCD)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cpu_sleep(cpu_sleep),
		.timer1_clock_input(t1_in), .panel(panel), .min_voltage(min_v),
		.internal_voltage_gen_on(internal_voltage_gen_on_on), .rc_osc_on(rc_on),
		.frame_start(frame_start), .frame_interrupt_flag(flag)
	);

	slcd_panel_model u_panel (
		.pclk(pclk), .presetn(presetn), .panel(panel), .min_voltage(min_v),
		.clr(clr), .seen_ff(seen), .seg_ff(seg), .bad_ff(bad)
	);

	function automatic logic [7:0] pix(input int i);
		return 8'(i * 37 + 5);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [8:0] idx, input logic [7:0] wd);
		int k;
		k = 0;
		@(posedge pclk);
		psel    <= 1'h1;
		pwrite  <= w;
		paddr   <= {1'h0, idx, 2'h0};
		pwdata  <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		rd = prdata;
		er = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		if (k >= 20) chk(32'h0, 32'h1);
	endtask

	task automatic wr(input logic [8:0] idx, input logic [7:0] d);
		apb(1'h1, idx, d);
	endtask

	task automatic rdc(input logic [8:0] idx, input logic [31:0] exp, input logic e);
		apb(1'h0, idx, 8'h00);
		chk(rd, exp);
		chk({31'h0, er}, {31'h0, e});
	endtask

	// Skips to the next frame start, then counts one whole frame.
	task automatic meas();
		n = 0;
		do begin @(posedge pclk); n++; end while (frame_start !== 1'h1 && n < 9000);
		cyc = 0;
		do begin @(posedge pclk); cyc++; end while (frame_start !== 1'h1 && cyc < 9000);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// The run needs about 22500 cycles; this leaves ample margin.
	initial begin
		#400000;
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		rdc(`SLCD_IDX_CONTROL, 32'h0, 1'h0);
		rdc(`SLCD_IDX_PRESCALE, 32'h0, 1'h0);
		// Pixels are loaded before any enable, so no fetch ever reads an unwritten byte.
		for (int i = 0; i < 16; i++) wr(`SLCD_IDX_PIX_BASE + 9'(i), pix(i));
		wr(`SLCD_IDX_CONTROL, 8'hFF);
		rdc(`SLCD_IDX_CONTROL, 32'hDF, 1'h0);
		wr(`SLCD_IDX_PRESCALE, 8'hFF);
		rdc(`SLCD_IDX_PRESCALE, 32'h0F, 1'h0);
		rdc(9'h000, 32'h0, 1'h1);
		chk({30'h0, internal_voltage_gen_on_on, rc_on}, 32'h3);
		wr(`SLCD_IDX_CONTROL, 8'h00);
		repeat (2) @(posedge pclk);
		chk({25'h0, panel.commons, min_v, rc_on, internal_voltage_gen_on_on}, 32'h4);
		for (int i = 0; i < 16; i++) rdc(`SLCD_IDX_PIX_BASE + 9'(i), {24'h0, pix(i)}, 1'h0);
		for (int m = 0; m < 4; m++) begin
			wr(`SLCD_IDX_PRESCALE, 8'(m));
			wr(`SLCD_IDX_CONTROL, 8'h88 | 8'(m));
			clr <= 1'h1;
			@(posedge pclk);
			clr <= 1'h0;
			meas();
			chk(32'(cyc), 32'((m == 2 ? 96 : 128) * (m + 1) * RCD));
			chk({28'h0, seen}, 32'((1 << (m + 1)) - 1));
		end
		for (int c = 0; c < 4; c++) chk(seg[c], {pix(4*c+3), pix(4*c+2), pix(4*c+1), pix(4*c)});
		meas();
		wr(`SLCD_IDX_FLAG, 8'h00);
		n = 0;
		do begin @(posedge pclk); n++; end while (flag !== 1'h1 && n < 9000);
		cyc = 0;
		do begin @(posedge pclk); cyc++; end while (frame_start !== 1'h1 && cyc < 9000);
		chk(32'(cyc), 32'(32 * 4 * RCD));
		rdc(`SLCD_IDX_FLAG, 32'h80, 1'h0);
		wr(`SLCD_IDX_PIX_BASE, 8'h5A);
		meas();
		chk(seg[0], {pix(3), pix(2), pix(1), 8'h5A});
		wr(`SLCD_IDX_PRESCALE, 8'h00);
		t1_run <= 1'h1;
		wr(`SLCD_IDX_CONTROL, 8'h87);
		meas();
		chk(32'(cyc), 32'h100);
		chk({31'h0, rc_on}, 32'h0);
		cpu_sleep <= 1'h1;
		meas();
		chk(32'(cyc), 32'h100);
		wr(`SLCD_IDX_CONTROL, 8'hC7);
		repeat (2) @(posedge pclk);
		chk({27'h0, panel.commons, min_v}, 32'h1);
		chk(panel.segments, 32'h0);
		cpu_sleep <= 1'h0;
		meas();
		chk(32'(cyc), 32'h100);
		wr(`SLCD_IDX_CONTROL, 8'h83);
		cpu_sleep <= 1'h1;
		repeat (2) @(posedge pclk);
		chk({31'h0, min_v}, 32'h1);
		cpu_sleep <= 1'h0;
		repeat (300) @(posedge pclk);
		chk({31'h0, min_v}, 32'h0);
		wr(`SLCD_IDX_CONTROL, 8'h08);
		wr(`SLCD_IDX_FLAG, 8'h00);
		repeat (1500) @(posedge pclk);
		rdc(`SLCD_IDX_FLAG, 32'h0, 1'h0);
		chk({31'h0, bad}, 32'h0);
		report_and_stop();
	end
endmodule // testbench
